// [rtl/cbbc_core.sv]
`timescale 1ns/1ps
`include "cbbc_defines.svh"
// Summary of operation
// (RULE_01) Bit xor: carry becomes carry xor selected operand bit.
// (RULE_02) Inverted bit xor: carry becomes carry xor inverted operand bit.
// (RULE_03) Inverted variants take bit number only from 3-bit immediate.
// (RULE_04) Bit load: selected operand bit copied into carry.
// (RULE_05) Inverted bit load: complement of selected bit into carry.
// (RULE_06) Bit store: carry written to selected bit, others kept.
// (RULE_07) Inverted bit store: complement of carry written to selected bit.
// (RULE_08) Conditional branch taken only when condition holds; always/never.
// (RULE_09) Single-flag conditions test carry, zero, overflow or negative.
// (RULE_10) Compound conditions: C or Z, N xor V, Z or (N xor V).
// (RULE_11) Unconditional jump loads target without testing flags.
// (RULE_12) Both subroutine calls branch to target and keep return point.
// (RULE_13) Return resumes at the most recent retained return point.
// (RULE_14) Plain bit ops take bit number from immediate or register low bits.
// (RULE_15) Call pushes next instruction address; return pops it into PC.
module cbbc_core (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_VALID,
	input wire cbbc_pkg::cbbc_op_t I_OP,
	input wire cbbc_pkg::cbbc_cc_t I_COND,
	input wire logic I_BIT_FROM_REG,
	input wire logic [2:0] I_BIT_IMM,
	input wire logic [7:0] I_BIT_REG,
	input wire logic [7:0] I_OPERAND,
	input wire logic I_FLAG_C,
	input wire logic I_FLAG_Z,
	input wire logic I_FLAG_V,
	input wire logic I_FLAG_N,
	input wire logic [31:0] I_PC,
	input wire logic [31:0] I_TARGET,
	output logic O_CARRY,
	output logic [7:0] O_BYTE,
	output logic O_TAKEN,
	output logic [31:0] O_PC,
	output logic O_DONE,
	output logic O_PUSH,
	output logic O_POP,
	output logic [31:0] O_PUSH_DATA
);
	import cbbc_pkg::*;

	// ======================================================================
	// Return-point stack
	// A small stack holds return points; a seventeenth nested call
	// overwrites the oldest entry, a limit software must respect.
	logic [31:0] ret_stack [0:15];
	cbbc_state_t state;
	cbbc_state_t next_state;
	logic [2:0] bit_sel;
	logic sel_bit;
	logic cond_true;
	logic [3:0] sp_top;

	// Bit number choice: inverted forms ignore the register source.
	always_comb
	begin
		bit_sel = I_BIT_IMM; // [RULE_03]
		if (I_BIT_FROM_REG && (I_OP == CBBC_OP_BIT_XOR_CARRY ||
			I_OP == CBBC_OP_BIT_TO_CARRY || I_OP == CBBC_OP_CARRY_TO_BIT))
		begin
			bit_sel = I_BIT_REG[2:0]; // [RULE_14]
		end
		sel_bit = I_OPERAND[bit_sel];
		sp_top = state.sp - 4'h1;
	end

	// Condition evaluation from the flag inputs.
	always_comb
	begin
		case (I_COND)
			CBBC_CC_BRANCH_ALWAYS: cond_true = 1'b1; // [RULE_08]
			CBBC_CC_BRANCH_NEVER: cond_true = 1'b0; // [RULE_08]
			CBBC_CC_BRANCH_HIGH: cond_true = !(I_FLAG_C | I_FLAG_Z); // [RULE_10]
			CBBC_CC_BRANCH_LOW_OR_SAME: cond_true = I_FLAG_C | I_FLAG_Z;
			CBBC_CC_BRANCH_CARRY_CLEAR: cond_true = !I_FLAG_C; // [RULE_09]
			CBBC_CC_BRANCH_CARRY_SET: cond_true = I_FLAG_C;
			CBBC_CC_BRANCH_NOT_EQUAL: cond_true = !I_FLAG_Z;
			CBBC_CC_BRANCH_EQUAL: cond_true = I_FLAG_Z;
			CBBC_CC_BRANCH_OVERFLOW_CLEAR: cond_true = !I_FLAG_V;
			CBBC_CC_BRANCH_OVERFLOW_SET: cond_true = I_FLAG_V;
			CBBC_CC_BRANCH_PLUS: cond_true = !I_FLAG_N;
			CBBC_CC_BRANCH_MINUS: cond_true = I_FLAG_N;
			CBBC_CC_BRANCH_GREATER_EQUAL: cond_true = !(I_FLAG_N ^ I_FLAG_V);
			CBBC_CC_BRANCH_LESS_THAN: cond_true = I_FLAG_N ^ I_FLAG_V;
			CBBC_CC_BRANCH_GREATER_THAN:
				cond_true = !(I_FLAG_Z | (I_FLAG_N ^ I_FLAG_V));
			CBBC_CC_BRANCH_LESS_EQUAL:
				cond_true = I_FLAG_Z | (I_FLAG_N ^ I_FLAG_V);
			default: cond_true = 1'b0;
		endcase
	end

	// ======================================================================
	// Next-state logic
	// Carry and byte follow the input by default so a result is always the
	// operand untouched unless a store operation edits one bit.
	always_comb
	begin
		next_state = state;
		next_state.done = I_VALID;
		next_state.taken = 1'b0;
		next_state.push = 1'b0;
		next_state.pop = 1'b0;
		next_state.carry = I_FLAG_C;
		next_state.byte_out = I_OPERAND;
		next_state.pc = I_PC + `CBBC_PC_STEP;
		if (I_VALID)
		begin
			case (I_OP)
				CBBC_OP_BIT_XOR_CARRY:
					next_state.carry = I_FLAG_C ^ sel_bit; // [RULE_01]
				CBBC_OP_INV_BIT_XOR_CARRY:
					next_state.carry = I_FLAG_C ^ !sel_bit; // [RULE_02]
				CBBC_OP_BIT_TO_CARRY:
					next_state.carry = sel_bit; // [RULE_04]
				CBBC_OP_INV_BIT_TO_CARRY:
					next_state.carry = !sel_bit; // [RULE_05]
				CBBC_OP_CARRY_TO_BIT:
					next_state.byte_out[bit_sel] = I_FLAG_C; // [RULE_06]
				CBBC_OP_INV_CARRY_TO_BIT:
					next_state.byte_out[bit_sel] = !I_FLAG_C; // [RULE_07]
				CBBC_OP_COND_BRANCH:
				begin
					next_state.taken = cond_true; // [RULE_08]
					if (cond_true)
					begin
						next_state.pc = I_TARGET;
					end
				end
				CBBC_OP_JUMP_UNCONDITIONAL:
				begin
					next_state.taken = 1'b1; // [RULE_11]
					next_state.pc = I_TARGET;
				end
				CBBC_OP_RELATIVE_SUBROUTINE_CALL,
				CBBC_OP_ABSOLUTE_SUBROUTINE_CALL:
				begin
					next_state.taken = 1'b1; // [RULE_12]
					next_state.pc = I_TARGET;
					next_state.push = 1'b1; // [RULE_15]
					next_state.push_data = I_PC + `CBBC_PC_STEP;
					next_state.sp = state.sp + 4'h1;
				end
				CBBC_OP_RETURN:
				begin
					next_state.taken = 1'b1; // [RULE_13]
					next_state.pop = 1'b1; // [RULE_15]
					next_state.pc = ret_stack[sp_top];
					next_state.push_data = ret_stack[sp_top];
					next_state.sp = sp_top;
				end
				default:
				begin
					next_state.done = 1'b1;
				end
			endcase
		end
	end

	// State register with asynchronous reset to constants.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			state <= '0;
			state.pc <= `CBBC_PC_RESET;
			state.sp <= `CBBC_SP_RESET;
			state.byte_out <= `CBBC_BYTE_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	// The stack array has no reset; only pushed entries are ever read.
	always_ff @(posedge I_CLK)
	begin
		if (I_VALID && (I_OP == CBBC_OP_RELATIVE_SUBROUTINE_CALL ||
			I_OP == CBBC_OP_ABSOLUTE_SUBROUTINE_CALL))
		begin
			ret_stack[state.sp] <= I_PC + `CBBC_PC_STEP; // [RULE_15]
		end
	end

	// Outputs come straight from the state register.
	assign O_CARRY = state.carry;
	assign O_BYTE = state.byte_out;
	assign O_TAKEN = state.taken;
	assign O_PC = state.pc;
	assign O_DONE = state.done;
	assign O_PUSH = state.push;
	assign O_POP = state.pop;
	assign O_PUSH_DATA = state.push_data;

	// ======================================================================
	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	chk_xor_carry: assert property ( // [RULE_01]
		I_VALID && I_OP == CBBC_OP_BIT_XOR_CARRY && !I_BIT_FROM_REG |=>
		O_CARRY == ($past(I_FLAG_C) ^ $past(I_OPERAND[I_BIT_IMM])))
		else $error("Bit xor carry wrong.");
	chk_inv_xor_carry: assert property ( // [RULE_02]
		I_VALID && I_OP == CBBC_OP_INV_BIT_XOR_CARRY |=>
		O_CARRY == ($past(I_FLAG_C) ^ !$past(I_OPERAND[I_BIT_IMM])))
		else $error("Inverted bit xor carry wrong.");
	chk_inv_imm_only: assert property ( // [RULE_03]
		I_VALID && I_OP == CBBC_OP_INV_BIT_TO_CARRY && I_BIT_FROM_REG |=>
		O_CARRY == !$past(I_OPERAND[I_BIT_IMM]))
		else $error("Inverted load used register bit number.");
	chk_load_reg_bit: assert property ( // [RULE_14]
		I_VALID && I_OP == CBBC_OP_BIT_TO_CARRY && I_BIT_FROM_REG |=>
		O_CARRY == $past(I_OPERAND[I_BIT_REG[2:0]]))
		else $error("Bit load from register number wrong.");
	chk_store_bit: assert property ( // [RULE_06]
		I_VALID && I_OP == CBBC_OP_CARRY_TO_BIT && !I_BIT_FROM_REG |=>
		O_BYTE[$past(I_BIT_IMM)] == $past(I_FLAG_C) &&
		((O_BYTE ^ $past(I_OPERAND)) &
		~(8'h01 << $past(I_BIT_IMM))) == 8'h00)
		else $error("Bit store wrong.");
	chk_inv_store_bit: assert property ( // [RULE_07]
		I_VALID && I_OP == CBBC_OP_INV_CARRY_TO_BIT |=>
		O_BYTE[$past(I_BIT_IMM)] == !$past(I_FLAG_C))
		else $error("Inverted bit store wrong.");
	chk_never_taken: assert property ( // [RULE_08]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_NEVER |=> !O_TAKEN)
		else $error("Never branch taken.");
	chk_gt_cond: assert property ( // [RULE_10]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_GREATER_THAN |=>
		O_TAKEN == !($past(I_FLAG_Z) | ($past(I_FLAG_N) ^ $past(I_FLAG_V))))
		else $error("Greater-than decision wrong.");
	chk_jump_target: assert property ( // [RULE_11]
		I_VALID && I_OP == CBBC_OP_JUMP_UNCONDITIONAL |=>
		O_TAKEN && O_PC == $past(I_TARGET))
		else $error("Jump did not load target.");
	chk_call_return: assert property ( // [RULE_13]
		I_VALID && I_OP == CBBC_OP_ABSOLUTE_SUBROUTINE_CALL ##1
		I_VALID && I_OP == CBBC_OP_RETURN |=>
		O_PC == $past(I_PC, 2) + `CBBC_PC_STEP)
		else $error("Return point lost.");
	chk_call_push: assert property ( // [RULE_12]
		I_VALID && I_OP == CBBC_OP_RELATIVE_SUBROUTINE_CALL |=>
		O_PUSH && O_PUSH_DATA == $past(I_PC) + `CBBC_PC_STEP)
		else $error("Call did not retain return point.");
	// Loads, decisions, returns and idle. Each load and decision compares with its inputs one edge
	// back, so a wrong bit number or flag shows on the very next result.
	chk_load_imm_bit: assert property ( // [RULE_04]
		I_VALID && I_OP == CBBC_OP_BIT_TO_CARRY && !I_BIT_FROM_REG |=>
		O_CARRY == $past(I_OPERAND[I_BIT_IMM]))
		else $error("Bit load from immediate number wrong.");
	chk_inv_load_bit: assert property ( // [RULE_05]
		I_VALID && I_OP == CBBC_OP_INV_BIT_TO_CARRY && !I_BIT_FROM_REG |=>
		O_CARRY == !$past(I_OPERAND[I_BIT_IMM]))
		else $error("Inverted bit load wrong.");
	chk_carry_cond: assert property ( // [RULE_09]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_CARRY_SET |=>
		O_TAKEN == $past(I_FLAG_C))
		else $error("Carry-set decision wrong.");
	chk_equal_cond: assert property ( // [RULE_09]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_EQUAL |=>
		O_TAKEN == $past(I_FLAG_Z))
		else $error("Equal decision wrong.");
	chk_high_cond: assert property ( // [RULE_10]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_HIGH |=>
		O_TAKEN == !($past(I_FLAG_C) | $past(I_FLAG_Z)))
		else $error("High decision wrong.");
	chk_le_cond: assert property ( // [RULE_10]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH &&
		I_COND == CBBC_CC_BRANCH_LESS_EQUAL |=>
		O_TAKEN == ($past(I_FLAG_Z) | ($past(I_FLAG_N) ^ $past(I_FLAG_V))))
		else $error("Less-or-equal decision wrong.");
	chk_branch_target: assert property ( // [RULE_08]
		I_VALID && I_OP == CBBC_OP_COND_BRANCH |=>
		O_PC == (O_TAKEN ? $past(I_TARGET) :
		$past(I_PC) + `CBBC_PC_STEP))
		else $error("Branch destination wrong.");
	chk_return_pop: assert property ( // [RULE_15]
		I_VALID && I_OP == CBBC_OP_RETURN |=>
		O_POP && O_TAKEN && !O_PUSH && O_PC == O_PUSH_DATA)
		else $error("Return did not pop the return point.");
	chk_idle_quiet: assert property ( // [RULE_08]
		!I_VALID |=> !O_DONE && !O_TAKEN && !O_PUSH && !O_POP)
		else $error("Flow change without a request.");

	cov_branch_taken: cover property (
		I_VALID && I_OP == CBBC_OP_COND_BRANCH ##1 O_TAKEN);
	cov_call_return: cover property (
		I_VALID && I_OP == CBBC_OP_ABSOLUTE_SUBROUTINE_CALL ##1
		I_VALID && I_OP == CBBC_OP_RETURN);
	cov_store: cover property (
		I_VALID && I_OP == CBBC_OP_CARRY_TO_BIT);
	cov_return_pop: cover property (
		I_VALID && I_OP == CBBC_OP_RETURN ##1 O_POP);
	cov_jump: cover property (
		I_VALID && I_OP == CBBC_OP_JUMP_UNCONDITIONAL ##1 O_TAKEN);
endmodule : cbbc_core

// [rtl/cbbc_defines.svh]
`ifndef CBBC_DEFINES_SVH
`define CBBC_DEFINES_SVH
// ==========================================================================
// Constants
`define CBBC_PC_RESET 32'h00000000
`define CBBC_PC_STEP 32'h00000002
`define CBBC_SP_RESET 4'h0
`define CBBC_BYTE_RESET 8'h00
`endif

// [rtl/cbbc_pkg.sv]
package cbbc_pkg;
	// ======================================================================
	// Operation codes of the execute step.
	typedef enum logic [3:0] {
		CBBC_OP_NONE,
		CBBC_OP_BIT_XOR_CARRY,
		CBBC_OP_INV_BIT_XOR_CARRY,
		CBBC_OP_BIT_TO_CARRY,
		CBBC_OP_INV_BIT_TO_CARRY,
		CBBC_OP_CARRY_TO_BIT,
		CBBC_OP_INV_CARRY_TO_BIT,
		CBBC_OP_COND_BRANCH,
		CBBC_OP_JUMP_UNCONDITIONAL,
		CBBC_OP_RELATIVE_SUBROUTINE_CALL,
		CBBC_OP_ABSOLUTE_SUBROUTINE_CALL,
		CBBC_OP_RETURN
	} cbbc_op_t;
	// Branch condition field.
	typedef enum logic [3:0] {
		CBBC_CC_BRANCH_ALWAYS,
		CBBC_CC_BRANCH_NEVER,
		CBBC_CC_BRANCH_HIGH,
		CBBC_CC_BRANCH_LOW_OR_SAME,
		CBBC_CC_BRANCH_CARRY_CLEAR,
		CBBC_CC_BRANCH_CARRY_SET,
		CBBC_CC_BRANCH_NOT_EQUAL,
		CBBC_CC_BRANCH_EQUAL,
		CBBC_CC_BRANCH_OVERFLOW_CLEAR,
		CBBC_CC_BRANCH_OVERFLOW_SET,
		CBBC_CC_BRANCH_PLUS,
		CBBC_CC_BRANCH_MINUS,
		CBBC_CC_BRANCH_GREATER_EQUAL,
		CBBC_CC_BRANCH_LESS_THAN,
		CBBC_CC_BRANCH_GREATER_THAN,
		CBBC_CC_BRANCH_LESS_EQUAL
	} cbbc_cc_t;
	typedef struct packed {
		logic carry;
		logic [7:0] byte_out;
		logic taken;
		logic [31:0] pc;
		logic [3:0] sp;
		logic done;
		logic [31:0] push_data;
		logic push;
		logic pop;
	} cbbc_state_t;
endpackage : cbbc_pkg

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import cbbc_pkg::*;
	// ======================================================================
	// Stimulus, observed outputs and model state
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	logic fr = 1'b0;
	logic fc = 1'b0, fz = 1'b0, fv = 1'b0, fn = 1'b0;
	cbbc_op_t op = CBBC_OP_NONE;
	cbbc_cc_t cond = CBBC_CC_BRANCH_ALWAYS;
	logic [2:0] imm = 3'h0;
	logic [7:0] breg = 8'h00, opnd = 8'h00, o_byte, e_byte;
	logic [31:0] pc = 32'h0, tgt = 32'h0, o_pc, o_pd, e_pc, e_pd;
	logic o_c, o_tk, o_dn, o_pu, o_po;
	logic e_c, e_tk, e_v, e_pu, e_po;
	bit have_exp = 0;
	logic [31:0] stk[$];
	int bad_count = 0, tests_run = 0, cycles = 0, seed = 60916;

	cbbc_core u_dut (.I_CLK(clk), .I_RST(rst), .I_VALID(valid), .I_OP(op),
		.I_COND(cond), .I_BIT_FROM_REG(fr), .I_BIT_IMM(imm),
		.I_BIT_REG(breg), .I_OPERAND(opnd), .I_FLAG_C(fc), .I_FLAG_Z(fz),
		.I_FLAG_V(fv), .I_FLAG_N(fn), .I_PC(pc), .I_TARGET(tgt),
		.O_CARRY(o_c), .O_BYTE(o_byte), .O_TAKEN(o_tk), .O_PC(o_pc),
		.O_DONE(o_dn), .O_PUSH(o_pu), .O_POP(o_po), .O_PUSH_DATA(o_pd));

	// Clock of 40 ns; the cycle ceiling stops a hung run.
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ======================================================================
	// Helpers
	task end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Flags are packed as {C, Z, V, N}; the table is indexed by condition.
	function logic cond_ok(input cbbc_cc_t cc, input logic [3:0] fl);
		logic [15:0] t;
		logic x, g, h;
		x = fl[0] ^ fl[1];
		g = fl[2] | x;
		h = fl[3] | fl[2];
		t = {g, ~g, x, ~x, fl[0], ~fl[0], fl[1], ~fl[1], fl[2], ~fl[2],
			fl[3], ~fl[3], h, ~h, 1'b0, 1'b1};
		return t[cc];
	endfunction : cond_ok

	// Drive one request, then check the answer to the previous one.
	task step(input logic v, input cbbc_op_t o, input cbbc_cc_t cc,
		input logic [2:0] im, input logic f, input logic [7:0] rg, od,
		input logic [3:0] fl, input logic [31:0] p, t);
		logic [2:0] b;
		logic [7:0] y;
		logic c, tk, pu, po;
		logic [31:0] d, pn;
		@(posedge clk);
		valid <= v; op <= o; cond <= cc; imm <= im; fr <= f; breg <= rg;
		opnd <= od; {fc, fz, fv, fn} <= fl; pc <= p; tgt <= t;
		// Only the plain bit operations may take the number from a register.
		b = (f && o inside {CBBC_OP_BIT_XOR_CARRY, CBBC_OP_BIT_TO_CARRY,
			CBBC_OP_CARRY_TO_BIT}) ? rg[2:0] : im;
		c = fl[3]; y = od; tk = 0; pu = 0; po = 0; d = p + 32'h2;
		if (v)
			case (o)
				CBBC_OP_BIT_XOR_CARRY: c = fl[3] ^ od[b];
				CBBC_OP_INV_BIT_XOR_CARRY: c = fl[3] ^ ~od[b];
				CBBC_OP_BIT_TO_CARRY: c = od[b];
				CBBC_OP_INV_BIT_TO_CARRY: c = ~od[b];
				CBBC_OP_CARRY_TO_BIT: y[b] = fl[3];
				CBBC_OP_INV_CARRY_TO_BIT: y[b] = ~fl[3];
				CBBC_OP_COND_BRANCH: tk = cond_ok(cc, fl);
				CBBC_OP_JUMP_UNCONDITIONAL: tk = 1;
				CBBC_OP_NONE: tk = 0;
				CBBC_OP_RETURN:
				begin
					tk = 1; po = 1; d = stk.pop_back();
				end
				default:
				begin
					tk = 1; pu = 1; stk.push_back(d);
				end
			endcase
		pn = po ? d : (tk ? t : p + 32'h2);
		@(negedge clk);
		if (have_exp)
		begin
			check({o_dn, o_tk, o_pu, o_po},
				{e_v, e_tk, e_pu, e_po});
			check(o_c, e_c);
			check(o_byte, e_byte);
			if (e_v) check(o_pc, e_pc);
			if (e_pu | e_po) check(o_pd, e_pd);
		end
		have_exp = 1; e_v = v; e_c = c; e_byte = y; e_tk = tk;
		e_pu = pu; e_po = po; e_pc = pn; e_pd = d;
	endtask : step

	// Reset empties the return stack; outputs must read zero meanwhile.
	task reset_dut;
		@(posedge clk);
		rst <= 1'b1;
		valid <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({o_c, o_byte, o_tk, o_dn, o_pu, o_po}, 32'h0);
		check(o_pc | o_pd, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		stk.delete();
		have_exp = 0;
	endtask : reset_dut

	// ======================================================================
	// Main sequence
	initial
	begin
		cbbc_op_t o;
		logic [31:0] r;
		reset_dut();
		// Every condition against every flag combination.
		for (int i = 0; i < 256; i++)
			step(1, CBBC_OP_COND_BRANCH,
				cbbc_cc_t'(i[7:4]), 3'h0, 0, 8'h0, 8'h0, i[3:0],
				32'h100 + i, 32'h8000 + i);
		// Each bit operation at every bit, both bit sources and carries.
		for (int i = 0; i < 192; i++)
			step(1, cbbc_op_t'(4'(1 + i % 6)),
				CBBC_CC_BRANCH_NEVER, 3'((i / 6) % 8), i[5],
				8'($random(seed)), 8'($random(seed)), {i[6], 3'h5},
				32'h40, 32'h0);
		// Nest calls to full depth, then unwind back to back.
		for (int i = 0; i < 32; i++)
			step(1, i < 16 ? (i[0] ?
				CBBC_OP_RELATIVE_SUBROUTINE_CALL :
				CBBC_OP_ABSOLUTE_SUBROUTINE_CALL) : CBBC_OP_RETURN,
				CBBC_CC_BRANCH_ALWAYS, 3'h0, 0, 8'h0, 8'h0, 4'h0,
				32'h1000 + 4 * i, 32'h2000 + 8 * i);
		// An idle step lets the last return be checked, and keeps a stale
		// request from reaching the design on the edge where reset is asserted.
		step(0, CBBC_OP_NONE, CBBC_CC_BRANCH_NEVER,
			3'h0, 0, 8'h0, 8'h0, 4'h0, 32'h0, 32'h0);
		reset_dut();
		// Random traffic; the stack is kept between empty and full.
		for (int i = 0; i < 1500; i++)
		begin
			r = $random(seed);
			o = cbbc_op_t'(4'(r[7:0] % 12));
			if (o == CBBC_OP_RETURN && stk.size() == 0)
				o = CBBC_OP_JUMP_UNCONDITIONAL;
			if (o inside {CBBC_OP_RELATIVE_SUBROUTINE_CALL,
				CBBC_OP_ABSOLUTE_SUBROUTINE_CALL} && stk.size() == 16)
				o = CBBC_OP_RETURN;
			step(r[8], o, cbbc_cc_t'(r[12:9]),
				r[15:13], r[16], 8'($random(seed)), r[24:17], r[28:25],
				$random(seed), $random(seed));
		end
		step(0, CBBC_OP_NONE, CBBC_CC_BRANCH_NEVER, 3'h0, 0, 8'h0, 8'h0, 4'h0, 32'h0, 32'h0);
		end_sim();
	end
endmodule : testbench
